// ### pkg/video_pkg.sv
// Purpose: Shared constants and types for the colour matrix and pixel packer
// Assumes: 8-bit channels, 24-bit pixel on the fixed side
// Notes: Byte addresses on APB, one 32-bit word per register
package video_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] COEF_BASE_OFS = 8'h00;
    localparam logic [7:0] PACK_CTRL_OFS = 8'h30;
    localparam logic [7:0] STATUS_OFS = 8'h34;
    localparam logic [7:0] PIX_COUNT_OFS = 8'h38;
    localparam int COEF_NUM = 12;
    localparam int COEF_W = 10;
    localparam int COEF_FRAC = 8;
    localparam logic [9:0] COEF_ONE = 10'h100;
    localparam logic [9:0] COEF_ZERO = 10'h000;

    // ----------------------------------------
    // Packer control field layout
    // ----------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RESAMPLE_BIT = 2;
    localparam int CTRL_UNPACK_BIT = 3;
    localparam logic [1:0] MODE_RESET = 2'h2;

    // ----------------------------------------
    // Width modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        BPP8 = 2'h0,
        BPP16 = 2'h1,
        BPP24 = 2'h2,
        BPP32 = 2'h3
    } bpp_mode_t;

    typedef struct packed {
        logic [7:0] ch3;
        logic [7:0] ch2;
        logic [7:0] ch1;
    } pixel_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] last_n;
    } packed_word_t;

endpackage

// ### core/colour_matrix.sv
// Purpose: 3x4 colour matrix with rounding and saturation
// Assumes: Coefficients signed 10-bit, two integer bits, eight fraction bits
// Notes: One register stage; output held until accepted
`timescale 1ns/100ps
module colour_matrix (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [119:0] coef,
    input wire logic in_valid,
    output logic in_ready,
    input wire video_pkg::pixel_t in_pix,
    output logic out_valid,
    input wire logic out_ready,
    output video_pkg::pixel_t out_pix
);
    logic [7:0] in_ch [3];
    logic [7:0] res [3];
    logic take;

    assign in_ch[0] = in_pix.ch1;
    assign in_ch[1] = in_pix.ch2;
    assign in_ch[2] = in_pix.ch3;
    assign in_ready = !out_valid || out_ready; // R13
    assign take = in_valid && in_ready;

    // ----------------------------------------
    // Per output channel
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            logic signed [9:0] c0, c1, c2, k;
            logic signed [20:0] acc;
            logic signed [20:0] rnd;
            assign c0 = signed'(coef[(3*g)*10 +: 10]); // R3
            assign c1 = signed'(coef[(3*g+1)*10 +: 10]);
            assign c2 = signed'(coef[(3*g+2)*10 +: 10]);
            assign k = signed'(coef[(9+g)*10 +: 10]);
            // R1
            // Widen before multiplying so no product is cut to operand width
            assign acc = 21'(c0) * 21'(signed'({1'b0, in_ch[0]}))
                       + 21'(c1) * 21'(signed'({1'b0, in_ch[1]}))
                       + 21'(c2) * 21'(signed'({1'b0, in_ch[2]}))
                       + 21'(k) * 21'sd255;
            // Round half up before dropping the fraction
            assign rnd = (acc + 21'sh80) >>> video_pkg::COEF_FRAC;
            // R14
            assign res[g] = rnd[20] ? 8'h00 : (|rnd[19:8] ? 8'hff : rnd[7:0]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
        end else if (take) begin
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pix <= '0;
        end else if (take) begin
            out_pix <= '{ch3: res[2], ch2: res[1], ch1: res[0]};
        end
    end

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R13
        out_valid && !out_ready |=> out_valid && $stable(out_pix))
        else $error("matrix output changed while stalled");
    AST_FILL: assert property (@(posedge pclk) disable iff (!presetn) // R1
        take |=> out_valid)
        else $error("matrix result not presented");
endmodule // colour_matrix

// ### core/video_pixel_path.sv
// Purpose: Colour matrix preceded by width unpacker or followed by width packer, APB programmed
// Assumes: Single pixel clock; stream inputs synchronous to pclk
// Notes: APB slave answers with pready one cycle after the setup cycle
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Operation
// R1: Each output channel is a linear sum of the three input channels plus a constant.
// R2: Each coefficient is a signed 10-bit number with two integer and eight fraction bits.
// R3: Outputs one to three use coefficients 1-3, 4-6, 7-9 with offsets 10, 11, 12.
// R4: Coefficients may be written while pixels flow and apply to later pixels.
// R5: The packer always takes 24-bit pixels and the unpacker always gives 24-bit pixels.
// R6: The width setting offers 8, 16, 24 and 32 bits per pixel.
// R7: In 8-bit mode pack keeps channel one and unpack zero-fills channels two and three.
// R8: In 24-bit mode both directions pass pixels unchanged.
// R9: In 32-bit mode pack adds a zero fourth channel and unpack drops it.
// R10: 16-bit with resampling alternates the two chroma channels on channel two.
// R11: 16-bit without resampling carries channels one and two and drops channel three.
// R12: Software should pause the stream before changing the width setting.
// R13: Stages use valid/ready, hold output until taken and stall input when full.
// R14: Matrix outputs are rounded and saturated to the 0..255 range.
module video_pixel_path (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [31:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [31:0] m_data
);
    logic [9:0] coef_q [video_pkg::COEF_NUM];
    logic [119:0] coef_flat;
    logic [1:0] mode_q;
    logic resample_q;
    logic unpack_q;
    logic [31:0] pix_count_q;
    logic phase_q;
    logic access;
    logic [3:0] widx;
    logic hit_coef;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign access = psel && penable && pready;
    assign widx = paddr[5:2];
    assign hit_coef = (paddr < 8'h30) && (paddr[1:0] == 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !(hit_coef || paddr == video_pkg::PACK_CTRL_OFS
                        || paddr == video_pkg::STATUS_OFS
                        || paddr == video_pkg::PIX_COUNT_OFS);
        end
    end

    // Unity matrix by default so video passes unchanged
    genvar gi;
    generate
        for (gi = 0; gi < video_pkg::COEF_NUM; gi++) begin : g_coef
            localparam logic [9:0] RST = (gi == 0 || gi == 4 || gi == 8)
                ? video_pkg::COEF_ONE : video_pkg::COEF_ZERO;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    coef_q[gi] <= RST;
                end else if (access && pwrite && hit_coef && widx == 4'(gi)) begin
                    coef_q[gi] <= pwdata[video_pkg::COEF_W-1:0]; // R2 R4
                end
            end
            assign coef_flat[gi*10 +: 10] = coef_q[gi];
        end
    endgenerate

    // Width change mid-stream is not guarded; software pauses first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= video_pkg::MODE_RESET;
            resample_q <= 1'b0;
            unpack_q <= 1'b0;
        end else if (access && pwrite && paddr == video_pkg::PACK_CTRL_OFS) begin
            mode_q <= pwdata[video_pkg::CTRL_MODE_LSB +: 2]; // R6 R12
            resample_q <= pwdata[video_pkg::CTRL_RESAMPLE_BIT];
            unpack_q <= pwdata[video_pkg::CTRL_UNPACK_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_coef) begin
                prdata <= {22'h00_0000, coef_q[widx]};
            end else if (paddr == video_pkg::PACK_CTRL_OFS) begin
                prdata <= {28'h000_0000, unpack_q, resample_q, mode_q};
            end else if (paddr == video_pkg::STATUS_OFS) begin
                prdata <= {28'h000_0000, phase_q, m_valid, s_ready, s_valid};
            end else if (paddr == video_pkg::PIX_COUNT_OFS) begin
                prdata <= pix_count_q;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Input side: matrix on 24-bit stream, or unpack first
    // ----------------------------------------
    video_pkg::pixel_t up_pix;
    video_pkg::pixel_t cm_in;
    video_pkg::pixel_t cm_out;
    logic cm_in_valid, cm_in_ready, cm_out_valid, cm_out_ready;
    logic [31:0] pk_word;

    // Unpacker: restore 24-bit pixel from narrow word
    always_comb begin
        up_pix = s_data[23:0];
        case (video_pkg::bpp_mode_t'(mode_q))
            video_pkg::BPP8: up_pix = {16'h0000, s_data[7:0]}; // R7
            video_pkg::BPP16: begin
                // R10 R11
                if (resample_q) begin
                    up_pix = phase_q ? {s_data[15:8], 8'h00, s_data[7:0]}
                                     : {8'h00, s_data[15:8], s_data[7:0]};
                end else begin
                    up_pix = {8'h00, s_data[15:8], s_data[7:0]};
                end
            end
            video_pkg::BPP24: up_pix = s_data[23:0]; // R8
            video_pkg::BPP32: up_pix = s_data[23:0]; // R9
            default: up_pix = s_data[23:0];
        endcase
    end

    // R5
    assign cm_in = unpack_q ? up_pix : video_pkg::pixel_t'(s_data[23:0]);
    assign cm_in_valid = s_valid;
    assign s_ready = cm_in_ready; // R13

    colour_matrix u_matrix (
        .pclk(pclk),
        .presetn(presetn),
        .coef(coef_flat),
        .in_valid(cm_in_valid),
        .in_ready(cm_in_ready),
        .in_pix(cm_in),
        .out_valid(cm_out_valid),
        .out_ready(cm_out_ready),
        .out_pix(cm_out)
    );

    // ----------------------------------------
    // Output side: pack matrix result to configured width, or pass 24-bit result when unpacking
    // ----------------------------------------
    always_comb begin
        pk_word = {8'h00, cm_out};
        if (!unpack_q) begin
            case (video_pkg::bpp_mode_t'(mode_q))
                video_pkg::BPP8: pk_word = {24'h00_0000, cm_out.ch1}; // R7
                video_pkg::BPP16: begin
                    // R10 R11
                    if (resample_q && phase_q) begin
                        pk_word = {16'h0000, cm_out.ch3, cm_out.ch1};
                    end else begin
                        pk_word = {16'h0000, cm_out.ch2, cm_out.ch1};
                    end
                end
                video_pkg::BPP24: pk_word = {8'h00, cm_out}; // R8
                video_pkg::BPP32: pk_word = {8'h00, cm_out}; // R9
                default: pk_word = {8'h00, cm_out};
            endcase
        end
    end

    assign cm_out_ready = !m_valid || m_ready; // R13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_valid <= 1'b0;
        end else if (cm_out_valid && cm_out_ready) begin
            m_valid <= 1'b1;
        end else if (m_ready) begin
            m_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_data <= 32'h0000_0000;
        end else if (cm_out_valid && cm_out_ready) begin
            m_data <= pk_word;
        end
    end

    // Chroma phase toggles per pixel on the narrow side of the path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
        end else if (mode_q != 2'(video_pkg::BPP16) || !resample_q) begin
            phase_q <= 1'b0;
        end else if (unpack_q ? (s_valid && s_ready) : (cm_out_valid && cm_out_ready)) begin
            phase_q <= !phase_q; // R10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_count_q <= 32'h0000_0000;
        end else if (m_valid && m_ready) begin
            pix_count_q <= pix_count_q + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_OUT_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R13
        m_valid && !m_ready |=> m_valid && $stable(m_data))
        else $error("output changed while stalled");
    AST_PACK8: assert property (@(posedge pclk) disable iff (!presetn) // R7
        cm_out_valid && cm_out_ready && !unpack_q && mode_q == 2'h0
        |=> m_data[31:8] == 24'h00_0000)
        else $error("8-bit pack not narrowed");
    AST_PACK32: assert property (@(posedge pclk) disable iff (!presetn) // R9
        cm_out_valid && cm_out_ready && mode_q == 2'h3 |=> m_data[31:24] == 8'h00)
        else $error("fourth channel not zero");
    AST_PASS24: assert property (@(posedge pclk) disable iff (!presetn) // R8
        cm_out_valid && cm_out_ready && mode_q == 2'h2 |=> m_data[23:0] == $past(cm_out))
        else $error("24-bit not passed through");
    AST_PHASE: assert property (@(posedge pclk) disable iff (!presetn) // R10
        mode_q != 2'h1 || !resample_q |=> !phase_q)
        else $error("phase active outside resample");
    AST_UNPACK8: assert property (@(posedge pclk) disable iff (!presetn) // R7
        unpack_q && mode_q == 2'h0 |-> up_pix[23:8] == 16'h0000)
        else $error("unpack 8-bit not zero filled");
    AST_COEF_WR: assert property (@(posedge pclk) disable iff (!presetn) // R4
        access && pwrite && hit_coef |=> coef_q[$past(widx)] == $past(pwdata[9:0]))
        else $error("coefficient write lost");
    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn) // R13
        psel && !penable |=> pready ##1 !pready)
        else $error("apb ready timing wrong");
endmodule // video_pixel_path

// ### bench/stream_partner.sv
// Purpose: Far-side stream source and sink for the pixel path
// Assumes: One pixel clock shared with the block
// Notes: Idle source data toggles every cycle so a stale word never passes for a pixel
`timescale 1ns/100ps
module stream_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    output logic s_valid,
    input wire logic s_ready,
    output logic [31:0] s_data,
    input wire logic m_valid,
    output logic m_ready,
    input wire logic [31:0] m_data
);
    logic [31:0] src_q[$];
    logic [31:0] got_q[$];

    initial begin
        s_valid = 1'b0;
        s_data = 32'h5a5a_a5a5;
        m_ready = 1'b0;
    end

    // ----------------------------------------
    // Source and sink
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_valid <= 1'b0;
            m_ready <= 1'b0;
        end else begin
            if (m_valid && m_ready) begin
                got_q.push_back(m_data);
            end
            // Slow sink accepts every other cycle to exercise back-pressure
            m_ready <= stall ? !m_ready : 1'b1;
            if (!s_valid || s_ready) begin
                if (src_q.size() > 0) begin
                    s_valid <= 1'b1;
                    s_data <= src_q.pop_front();
                end else begin
                    s_valid <= 1'b0;
                    s_data <= ~s_data;
                end
            end
        end
    end
endmodule // stream_partner

// ### bench/tb.sv
// Purpose: Self-checking bench for the colour matrix and width packer
// Assumes: Zero-wait APB slave, two-stage stream pipeline
// Notes: Mode changes happen only with the stream drained
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stall = 1'b0;
    logic seen = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, s_data, m_data, rd, w, e0;
    logic pready, pslverr, s_valid, s_ready, m_valid, m_ready, err;
    int failures = 0;
    int compares = 0;
    int n_out = 0;
    logic [9:0] mix [12] = '{10'h000, 10'h000, 10'h100, 10'h200, 10'h100, 10'h000,
        10'h100, 10'h000, 10'h000, 10'h100, 10'h000, 10'h000};
    logic [3:0] ctl [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [31:0] din [9] = '{32'h00c3_b2a1, 32'h00c3_b2a1, 32'h00c3_b2a1, 32'h00c3_b2a1,
        32'h00c3_b2a1, 32'hddc3_b2a1, 32'hddc3_b2a1, 32'h00c3_b2a1, 32'hddc3_b2a1};
    logic [31:0] dex [9] = '{32'h0000_00a1, 32'h0000_b2a1, 32'h00c3_b2a1, 32'h00c3_b2a1,
        32'h00c3_b2a1, 32'h0000_00a1, 32'h0000_b2a1, 32'h00c3_b2a1, 32'h00c3_b2a1};

    always #5 pclk = ~pclk;

    video_pixel_path u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
        .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data));
    stream_partner u_far (.pclk(pclk), .presetn(presetn), .stall(stall), .s_valid(s_valid),
        .s_ready(s_ready), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
        .m_data(m_data));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [9:0] ident(input int i);
        return (i == 0 || i == 4 || i == 8) ? 10'h100 : 10'h000;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic get(output logic [31:0] v);
        int n;
        n = 0;
        while (u_far.got_q.size() == 0) begin
            @(posedge pclk);
            n++;
        end
        v = u_far.got_q.pop_front();
        n_out++;
    endtask

    task automatic px(input logic [31:0] d, input logic [31:0] exp);
        u_far.src_q.push_back(d);
        get(w);
        chk(w, exp);
    endtask

    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            apb(8'(4 * i), 1'b0, 32'h0000_0000);
            chk(rd, {22'h0, ident(i)});
        end
        apb(8'h30, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        apb(8'h3c, 1'b1, 32'hffff_ffff);
        chk({31'h0, err}, 32'h0000_0001);
        apb(8'h08, 1'b1, 32'hffff_feab);
        apb(8'h08, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_02ab);
        // Back to unity so the burst below passes unchanged
        apb(8'h08, 1'b1, 32'h0000_0000);
        // Burst against a stalling sink keeps order and loses nothing
        stall <= 1'b1;
        for (int i = 0; i < 8; i++) u_far.src_q.push_back(32'h0001_0203 * i);
        for (int i = 0; i < 8; i++) begin
            get(w);
            chk(w, 32'h0001_0203 * i);
        end
        for (int i = 0; i < 12; i++) apb(8'(4 * i), 1'b1, {22'h0, mix[i]});
        px(32'h0033_5010, 32'h0010_30ff);
        px(32'h0000_2040, 32'h0040_00ff);
        for (int i = 0; i < 16; i++) u_far.src_q.push_back(32'h0000_2040);
        repeat (6) @(posedge pclk);
        apb(8'h2c, 1'b1, 32'h0000_0100);
        for (int i = 0; i < 16; i++) begin
            get(w);
            if (w === 32'h00ff_00ff) seen = 1'b1;
            chk(w, seen ? 32'h00ff_00ff : 32'h0040_00ff);
        end
        chk({31'h0, seen}, 32'h0000_0001);
        stall <= 1'b0;
        for (int i = 0; i < 12; i++) apb(8'(4 * i), 1'b1, {22'h0, ident(i)});
        for (int i = 0; i < 9; i++) begin
            apb(8'h30, 1'b1, {28'h0, ctl[i]});
            px(din[i], dex[i]);
        end
        apb(8'h30, 1'b1, 32'h0000_0005);
        apb(8'h34, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        e0 = 32'h0000_b2a1;
        px(32'h00c3_b2a1, e0);
        px(32'h00c3_b2a1, 32'h0000_c3a1);
        apb(8'h30, 1'b1, 32'h0000_000d);
        px(32'h0000_b2a1, 32'h0000_b2a1);
        px(32'h0000_c3a1, 32'h00c3_00a1);
        apb(8'h38, 1'b0, 32'h0000_0000);
        chk(rd, 32'(n_out));
        end_sim();
    end
endmodule // tb
